// ===== inc/bdu_pkg.sv
package bdu_pkg;
  // Debug register select codes on the move-instruction port
  localparam logic [2:0] SEL_ADDR0 = 3'h0;
  localparam logic [2:0] SEL_ADDR3 = 3'h3;
  localparam logic [2:0] SEL_STATUS = 3'h6;
  localparam logic [2:0] SEL_CONTROL = 3'h7;
  localparam int NUM_BP = 4;

  // Access-type field codes
  localparam logic [1:0] TYPE_EXEC = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_RDWR = 2'h3;
  // Watch-length and access-size codes
  localparam logic [1:0] LEN_BYTE = 2'h0;
  localparam logic [1:0] LEN_HALF = 2'h1;
  localparam logic [1:0] LEN_WORD = 2'h3;

  // Control register field positions
  localparam int CTL_LOCAL0 = 0;
  localparam int CTL_LEXACT = 8;
  localparam int CTL_GEXACT = 9;
  localparam int CTL_GUARD = 13;
  localparam int CTL_TYPE0 = 16;
  localparam int CTL_LEN0 = 18;
  localparam int CTL_FIELD_STEP = 4;
  // Status register field positions
  localparam int STS_HIT0 = 0;
  localparam int STS_STEP = 14;
  localparam int STS_TASK = 15;

  // Reset values, writable masks and fixed reserved read values
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] CTL_RST = 32'h0000_0400;
  localparam logic [31:0] CTL_WMASK = 32'hFFFF_23FF;
  localparam logic [31:0] CTL_FIXED = 32'h0000_0400;
  localparam logic [31:0] STS_FIXED = 32'h0000_0FF0;
  localparam logic [3:0] HIT_RST = 4'h0;
  localparam logic [1:0] PRIV_KERNEL = 2'h0;

  // Byte lanes covered inside one aligned dword by an address and length
  function automatic logic [3:0] bdu_lanes(input logic [1:0] lo,
                                           input logic [1:0] len);
    logic [3:0] m;
    m = 4'h0;
    case (len)
      LEN_BYTE: m = 4'h1 << lo;
      LEN_HALF: m = lo[1] ? 4'hC : 4'h3;
      LEN_WORD: m = 4'hF;
      default: m = 4'h0;
    endcase
    return m;
  endfunction
endpackage

// ===== rtl/bdu_match.sv
`timescale 1ns/1ps
// One breakpoint comparator against the fetch and data access streams
module bdu_match
  import bdu_pkg::*;
(
  input wire logic [31:0] bp_addr,
  input wire logic [1:0] bp_type,
  input wire logic [1:0] bp_len,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic data_valid,
  input wire logic data_write,
  input wire logic [31:0] data_addr,
  input wire logic [1:0] data_size,
  output logic hit
);
  wire [3:0] bp_lanes = bdu_lanes(bp_addr[1:0], bp_len);
  wire [3:0] fetch_lanes = bdu_lanes(fetch_addr[1:0], LEN_BYTE);
  wire [3:0] data_lanes = bdu_lanes(data_addr[1:0], data_size);
  wire fetch_same = fetch_addr[31:2] == bp_addr[31:2];
  wire data_same = data_addr[31:2] == bp_addr[31:2];
  // Fetch side only knows the first byte of an instruction
  wire fetch_hit = fetch_valid && (bp_type == TYPE_EXEC) && fetch_same &&
                   |(fetch_lanes & bp_lanes); // see RL2 see RL3
  wire type_ok = (bp_type == TYPE_RDWR) ||
                 ((bp_type == TYPE_WRITE) && data_write);
  wire data_hit = data_valid && type_ok && data_same &&
                  |(data_lanes & bp_lanes); // see RL2 see RL3

  assign hit = fetch_hit || data_hit;
endmodule // bdu_match

// ===== rtl/bdu_top.sv
`timescale 1ns/1ps
// Overview of operation
// RL1: Four breakpoint linear address registers compared.
// RL2: Access type selects execute, write, or read/write.
// RL3: Length field watches one, two or four bytes.
// RL4: Execute breakpoint traps before the instruction runs.
// RL5: Hit flags set on exception, even disabled.
// RL6: Task-switch flag set on trapped task entry.
// RL7: Single-step flag set when trap flag caused it.
// RL8: Status bits persist until software clears them.
// RL9: Global enables apply always, survive task switch.
// RL10: Local enables cleared on every task switch.
// RL11: Access guard bit cleared on any exception.
// RL12: Debug register moves only at privilege zero.
// RL13: Trap flag raises exception after each instruction.
// RL14: Software preserves reserved control and status bits.
// RL15: Fixed field layout of control and status registers.
module bdu_top
  import bdu_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic dr_req,
  input wire logic dr_write,
  input wire logic [2:0] dr_sel,
  input wire logic [31:0] dr_wdata,
  input wire logic [1:0] cur_priv,
  output logic [31:0] dr_rdata,
  output logic dr_ack,
  output logic dr_fault,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic data_valid,
  input wire logic data_write,
  input wire logic [31:0] data_addr,
  input wire logic [1:0] data_size,
  input wire logic retire_valid,
  input wire logic trap_flag,
  input wire logic task_switch,
  input wire logic task_trap_bit,
  output logic dbg_exc,
  output logic fetch_break
);
  import bdu_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] addr_q [NUM_BP];
  logic [31:0] ctl_q;
  logic [31:0] ctl_d;
  logic [3:0] hit_q;
  logic [3:0] hit_d;
  logic step_q;
  logic step_d;
  logic task_q;
  logic task_d;
  logic [31:0] rdata_q;
  logic ack_q;
  logic fault_q;

  //////////////////////////////////////////////////////////////////////
  // Breakpoint comparators
  logic [3:0] raw_hit;
  logic [3:0] fetch_only_hit;
  logic [3:0] bp_enabled;

  for (genvar i = 0; i < NUM_BP; i++)
  begin : g_bp
    wire [1:0] bp_type = ctl_q[CTL_TYPE0 + CTL_FIELD_STEP*i +: 2];
    wire [1:0] bp_len = ctl_q[CTL_LEN0 + CTL_FIELD_STEP*i +: 2];
    // see RL9 see RL10
    assign bp_enabled[i] = ctl_q[CTL_LOCAL0 + 2*i] |
                           ctl_q[CTL_LOCAL0 + 2*i + 1];
    assign fetch_only_hit[i] = fetch_valid && (bp_type == TYPE_EXEC) &&
                               raw_hit[i];
    bdu_match u_match (
      .bp_addr(addr_q[i]), // see RL1
      .bp_type(bp_type),
      .bp_len(bp_len),
      .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr),
      .data_valid(data_valid),
      .data_write(data_write),
      .data_addr(data_addr),
      .data_size(data_size),
      .hit(raw_hit[i])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // Access decode
  wire guard_on = ctl_q[CTL_GUARD];
  wire priv_ok = cur_priv == PRIV_KERNEL;
  wire priv_bad = dr_req && !priv_ok; // see RL12
  // A privileged move while the guard is set traps instead of completing
  wire guard_trap = dr_req && priv_ok && guard_on;
  wire acc_ok = dr_req && priv_ok && !guard_on;
  wire wr_ok = acc_ok && dr_write;
  wire sel_addr = dr_sel <= SEL_ADDR3;
  wire wr_ctl = wr_ok && (dr_sel == SEL_CONTROL);
  wire wr_sts = wr_ok && (dr_sel == SEL_STATUS);

  //////////////////////////////////////////////////////////////////////
  // Exception causes
  // Fetch break is combinational so the core can squash the instruction
  assign fetch_break = |(fetch_only_hit & bp_enabled); // see RL4
  wire bp_trap = |(raw_hit & bp_enabled);
  wire step_trap = retire_valid && trap_flag; // see RL13
  wire task_trap = task_switch && task_trap_bit;
  wire exc = bp_trap || step_trap || task_trap || guard_trap;
  assign dbg_exc = exc;

  //////////////////////////////////////////////////////////////////////
  // Control register next value
  wire [31:0] ctl_wr = (dr_wdata & CTL_WMASK) | CTL_FIXED;
  wire [31:0] ctl_base = wr_ctl ? ctl_wr : ctl_q;
  // Local enables are the even bits of the low byte
  wire [31:0] local_mask = 32'h0000_0055;
  wire [31:0] ctl_ts = task_switch ? (ctl_base & ~local_mask) : ctl_base;
  always_comb
  begin
    ctl_d = ctl_ts; // see RL10 see RL9
    if (exc)
    begin
      ctl_d[CTL_GUARD] = 1'b0; // see RL11
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status register next value: hardware sets win over software writes
  wire [3:0] hit_base = wr_sts ? dr_wdata[STS_HIT0 +: NUM_BP] : hit_q;
  wire step_base = wr_sts ? dr_wdata[STS_STEP] : step_q;
  wire task_base = wr_sts ? dr_wdata[STS_TASK] : task_q;
  always_comb
  begin
    hit_d = hit_base; // see RL8
    step_d = step_base;
    task_d = task_base;
    if (exc)
    begin
      hit_d = hit_base | raw_hit; // see RL5
      step_d = step_base | step_trap; // see RL7
      task_d = task_base | task_trap; // see RL6
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux with fixed reserved values
  wire [31:0] sts_view = STS_FIXED | ({28'h0, hit_q} << STS_HIT0) |
                         ({31'h0, step_q} << STS_STEP) |
                         ({31'h0, task_q} << STS_TASK); // see RL15
  logic [31:0] rd_mux;
  always_comb
  begin
    if (sel_addr)
    begin
      rd_mux = addr_q[dr_sel[1:0]];
    end
    else if (dr_sel == SEL_STATUS)
    begin
      rd_mux = sts_view;
    end
    else if (dr_sel == SEL_CONTROL)
    begin
      rd_mux = ctl_q;
    end
    else
    begin
      rd_mux = 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctl_q <= CTL_RST;
      hit_q <= HIT_RST;
      step_q <= 1'b0;
      task_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
      hit_q <= hit_d;
      step_q <= step_d;
      task_q <= task_d;
    end
  end

  for (genvar j = 0; j < NUM_BP; j++)
  begin : g_addr
    wire wr_this = wr_ok && sel_addr && (dr_sel[1:0] == 2'(j));
    always_ff @(posedge clk)
    begin
      if (!rstn)
      begin
        addr_q[j] <= ADDR_RST;
      end
      else if (wr_this)
      begin
        addr_q[j] <= dr_wdata; // see RL1
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      ack_q <= acc_ok;
      fault_q <= priv_bad; // see RL12
      if (acc_ok && !dr_write)
      begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign dr_rdata = rdata_q;
  assign dr_ack = ack_q;
  assign dr_fault = fault_q;

  //////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  guard_clear_a: assert property (exc |=> !ctl_q[CTL_GUARD]) // see RL11
    else $error("guard bit survived a debug exception");

  local_clear_a: assert property ( // see RL10
    task_switch |=> (ctl_q & 32'h0000_0055) == 32'h0)
    else $error("local enable survived a task switch");

  global_keep_a: assert property ( // see RL9
    (task_switch && !wr_ctl) |=>
      ctl_q[7:0] == ($past(ctl_q[7:0]) & 8'hAA))
    else $error("global enable changed on task switch");

  hit_set_a: assert property ( // see RL5
    (exc && raw_hit[0]) |=> hit_q[0])
    else $error("hit flag not set for matched breakpoint");

  status_keep_a: assert property ( // see RL8
    (!wr_sts && !exc) |=> (hit_q == $past(hit_q)) &&
      (step_q == $past(step_q)) && (task_q == $past(task_q)))
    else $error("status changed without write or exception");

  step_flag_a: assert property ( // see RL7 see RL13
    step_trap |-> dbg_exc ##1 step_q)
    else $error("single step did not trap and flag");

  task_flag_a: assert property (task_trap |=> task_q) // see RL6
    else $error("task trap flag not set");

  priv_block_a: assert property ( // see RL12
    priv_bad |=> dr_fault && !dr_ack &&
      (ctl_q == $past(ctl_q)))
    else $error("unprivileged debug register access completed");

  exec_early_a: assert property ( // see RL4
    fetch_break |-> dbg_exc)
    else $error("execute breakpoint without exception");

  enable_gate_a: assert property ( // see RL9
    (bp_enabled == 4'h0 && !step_trap && !task_trap && !guard_trap)
      |-> !dbg_exc)
    else $error("exception from disabled breakpoints");

  reserved_view_a: assert property ( // see RL15
    (dr_ack && $past(dr_sel) == SEL_STATUS && !$past(dr_write)) |->
      dr_rdata[11:4] == 8'hFF && dr_rdata[31:16] == 16'h0)
    else $error("status reserved bits read wrong");

  addr_load_a: assert property ( // see RL1
    (wr_ok && sel_addr) |=>
      addr_q[$past(dr_sel[1:0])] == $past(dr_wdata))
    else $error("breakpoint address write lost");

  hit_all_a: assert property ( // see RL5
    exc |=> (hit_q & $past(raw_hit)) == $past(raw_hit))
    else $error("matched breakpoint missing from hit flags");

  step_only_a: assert property ( // see RL7
    (!step_trap && !wr_sts) |=> step_q == $past(step_q))
    else $error("single step flag moved without a step trap");

  task_only_a: assert property ( // see RL6
    (!task_trap && !wr_sts) |=> task_q == $past(task_q))
    else $error("task switch flag moved without a task trap");

  guard_hold_a: assert property ( // see RL11
    (!exc && !wr_ctl) |=> ctl_q[CTL_GUARD] == $past(ctl_q[CTL_GUARD]))
    else $error("guard bit changed without write or exception");

  ctl_fixed_a: assert property ( // see RL15
    (ctl_q & ~CTL_WMASK) == CTL_FIXED)
    else $error("control reserved bits lost their fixed values");

  ack_priv_a: assert property ( // see RL12
    dr_ack |-> $past(cur_priv) == PRIV_KERNEL)
    else $error("debug register access completed off privilege zero");
endmodule // bdu_top

// ===== test/bdu_core_model.sv
`timescale 1ns/1ps
// Core side: issues fetches and data accesses, retires what it executed
module bdu_core_model (
  input wire logic clk,
  input wire logic go_f,
  input wire logic go_d,
  input wire logic go_w,
  input wire logic [31:0] go_a,
  input wire logic [1:0] go_sz,
  input wire logic fetch_break,
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  output logic data_valid,
  output logic data_write,
  output logic [31:0] data_addr,
  output logic [1:0] data_size,
  output logic retire_valid = 1'b0
);
  logic [31:0] last_q = 32'h0;
  // Idle address buses show the inverse so a stale match cannot pass
  assign fetch_valid = go_f;
  assign fetch_addr = go_f ? go_a : ~last_q;
  assign data_valid = go_d;
  assign data_write = go_w;
  assign data_addr = go_d ? go_a : ~last_q;
  assign data_size = go_sz;
  always @(posedge clk)
  begin
    last_q <= go_a;
    // A stopped fetch is never executed, so it never retires
    retire_valid <= go_f & ~fetch_break;
  end
endmodule // bdu_core_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  import bdu_pkg::*;
  logic clk = 0, rstn = 0, dr_req = 0, dr_write = 0, trap_flag = 0;
  logic task_switch = 0, task_trap_bit = 0, go_f = 0, go_d = 0, go_w = 0;
  logic [2:0] dr_sel = 3'h0;
  logic [1:0] cur_priv = 2'h0, go_sz = 2'h0, data_size;
  logic [31:0] dr_wdata = 32'h0, go_a = 32'h0, dr_rdata, fetch_addr;
  logic [31:0] data_addr, ba, m_ctl = CTL_RST, m_sts = 32'h0;
  logic [31:0] m_addr [4] = '{default: ADDR_RST};
  logic dr_ack, dr_fault, fetch_valid, data_valid, data_write;
  logic retire_valid, dbg_exc, fetch_break;
  int err_total = 0, checks_done = 0;
  bit rp = 0;

  bdu_top bdu_top_inst (.clk(clk), .rstn(rstn), .dr_req(dr_req),
    .dr_write(dr_write), .dr_sel(dr_sel), .dr_wdata(dr_wdata),
    .cur_priv(cur_priv), .dr_rdata(dr_rdata), .dr_ack(dr_ack),
    .dr_fault(dr_fault), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .data_valid(data_valid),
    .data_write(data_write), .data_addr(data_addr),
    .data_size(data_size), .retire_valid(retire_valid),
    .trap_flag(trap_flag), .task_switch(task_switch),
    .task_trap_bit(task_trap_bit), .dbg_exc(dbg_exc),
    .fetch_break(fetch_break));
  bdu_core_model bdu_core_model_inst (.clk(clk), .go_f(go_f), .go_d(go_d),
    .go_w(go_w), .go_a(go_a), .go_sz(go_sz), .fetch_break(fetch_break),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .data_valid(data_valid), .data_write(data_write),
    .data_addr(data_addr), .data_size(data_size),
    .retire_valid(retire_valid));

  initial
    forever #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Raw match of one breakpoint, enables ignored
  function automatic bit mhit(int i, bit f, bit w, logic [31:0] a, int n);
    logic [3:0] c;
    int bn, b, x;
    c = m_ctl[16+4*i+:4];
    bn = c[3:2] == 0 ? 1 : c[3:2] == 1 ? 2 : c[3:2] == 3 ? 4 : 0;
    b = bn == 0 ? 0 : m_addr[i][1:0] / bn * bn;
    x = a[1:0];
    if (f ? c[1:0] != 0 : !(c[1:0] == 3 || (c[1:0] == 1 && w)))
      return 0;
    return bn != 0 && a[31:2] == m_addr[i][31:2] && b < x + n && x < b + bn;
  endfunction

  // One core cycle; the next step or register move replaces its inputs
  task automatic step(bit f, bit d, bit w, logic [31:0] a, logic [1:0] sz,
                      bit ts, bit tt);
    logic [31:0] h;
    bit en, fb, ex, st;
    h = 0;
    en = 0;
    fb = 0;
    st = rp && trap_flag;
    for (int i = 0; i < 4; i++)
    begin
      h[i] = (f && mhit(i, 1, 0, a, 1)) || (d && mhit(i, 0, w, a, sz + 1));
      en = en || (h[i] && m_ctl[2*i+:2] != 0);
      fb = fb || (f && h[i] && m_ctl[2*i+:2] != 0);
    end
    ex = en || st || (ts && tt);
    @(negedge clk);
    go_f = f;
    go_d = d;
    go_w = w;
    go_a = a;
    go_sz = sz;
    task_switch = ts;
    task_trap_bit = tt;
    #3 chk("dbg_exc", ex, dbg_exc);
    chk("fetch_break", fb, fetch_break);
    @(posedge clk);
    if (ex)
      m_sts = m_sts | h | {16'h0, ts && tt, st, 14'h0};
    if (ex)
      m_ctl[13] = 0;
    if (ts)
      m_ctl = m_ctl & ~32'h55;
    rp = f && !fb;
  endtask

  task automatic dr(bit w, logic [2:0] s, logic [31:0] d, logic [1:0] p);
    logic [31:0] e;
    bit g, ok;
    g = p == 0 && m_ctl[13];
    ok = p == 0 && !g;
    e = s == 6 ? STS_FIXED | m_sts : s == 7 ? m_ctl : 0;
    e = s < 4 ? m_addr[s[1:0]] : e;
    @(negedge clk);
    go_f = 0;
    go_d = 0;
    task_switch = 0;
    dr_req = 1;
    dr_write = w;
    dr_sel = s;
    dr_wdata = d;
    cur_priv = p;
    #3 chk("guard trap", g, dbg_exc);
    @(negedge clk);
    dr_req = 0;
    chk("dr_ack", ok, dr_ack);
    chk("dr_fault", p != 0, dr_fault);
    if (ok && !w)
      chk("dr_rdata", e, dr_rdata);
    if (ok && w && s < 4)
      m_addr[s[1:0]] = d;
    if (ok && w && s == 6)
      m_sts = d & 32'hC00F;
    if (ok && w && s == 7)
      m_ctl = d & CTL_WMASK | CTL_FIXED;
    if (g)
      m_ctl[13] = 0;
    rp = 0;
  endtask

  initial
  begin
    #100000;
    err_total++;
    end_sim;
  end

  initial
  begin
    void'($urandom(32'hda295c15));
    repeat (8) @(negedge clk);
    rstn = 1;
    dr(0, SEL_CONTROL, 0, 0);
    dr(0, SEL_STATUS, 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      dr(1, 3'(i), $urandom, 0);
      dr(0, 3'(i), 0, 0);
    end
    dr(0, 3'h4, 0, 0);
    dr(1, SEL_ADDR0, 32'h1234_5678, 2'h3);
    dr(0, SEL_ADDR0, 0, 0);
    ba = $urandom;
    dr(1, SEL_ADDR0, ba, 0);
    dr(1, 3'h1, ba, 0);
    dr(1, 3'h2, ba, 0);
    // Every type and length code, reserved bit 10 kept at its value
    for (int c = 0; c < 16; c++)
    begin
      dr(1, SEL_CONTROL, CTL_FIXED | 32'h2 | 32'(c) << 16, 0);
      step(1, 0, 0, ba, 0, 0, 0);
      step(0, 1, 0, {ba[31:2], 2'h0}, LEN_WORD, 0, 0);
      step(0, 1, 0, {ba[31:2], 2'($urandom) & 2'h2}, LEN_HALF, 0, 0);
      step(0, 1, 1, {ba[31:2], 2'($urandom)}, LEN_BYTE, 0, 0);
    end
    dr(0, SEL_STATUS, 0, 0);
    dr(1, SEL_STATUS, STS_FIXED, 0);
    dr(1, SEL_CONTROL, CTL_FIXED | 32'h0FD0_0008, 0);
    step(0, 1, 1, ba, LEN_BYTE, 0, 0);
    step(0, 1, 0, ba, LEN_BYTE, 0, 0);
    dr(0, SEL_STATUS, 0, 0);
    dr(1, SEL_CONTROL, CTL_FIXED | 32'h0FD0_0009, 0);
    trap_flag = 1;
    step(1, 0, 0, ~ba, 0, 0, 0);
    step(1, 0, 0, ba, 0, 0, 0);
    step(0, 0, 0, 0, 0, 0, 0);
    @(negedge clk);
    trap_flag = 0;
    dr(0, SEL_STATUS, 0, 0);
    step(0, 0, 0, 0, 0, 1, 0);
    dr(0, SEL_CONTROL, 0, 0);
    step(0, 0, 0, 0, 0, 1, 1);
    dr(0, SEL_STATUS, 0, 0);
    dr(1, SEL_CONTROL, CTL_FIXED | 32'h0FD0_2008, 0);
    dr(0, SEL_CONTROL, 0, 0);
    dr(1, SEL_CONTROL, CTL_FIXED | 32'h0FD0_2008, 0);
    step(0, 1, 1, ba, LEN_BYTE, 0, 0);
    dr(0, SEL_CONTROL, 0, 0);
    end_sim;
  end
endmodule // tb
